// >>> logic/ledl_core.sv
// Functional notes
// (RULE1) Edge pulse compares present condition with stored one, then stores present.
// (RULE2) Rising pulse: stored OFF and present ON drives bit ON.
// (RULE3) Rising pulse: stored ON drives bit OFF whatever present condition.
// (RULE4) Falling pulse: stored ON and present OFF drives bit ON.
// (RULE5) Falling pulse: stored OFF drives bit OFF whatever present condition.
// (RULE6) Edge pulses and latch leave arithmetic and error flags unchanged.
// (RULE7) Latch set turns bit ON and holds it until reset.
// (RULE8) Latch reset turns bit OFF and holds it until set.
// (RULE9) Set and reset together: reset wins, bit OFF.
// (RULE10) Holding and auxiliary area latch bits survive power interruption.
// (RULE11) Latch bits keep their state when an interlock becomes active.
// (RULE12) Open interlock: each line to the clear starts ON, executes normally.
// (RULE13) Blocked interlock: coils OFF, timers reset, counters and latches held.
// (RULE14) Several opens in a row each start a section to the next clear.
// (RULE15) Program places an open between any two clears.
// (RULE16) Program lets one instruction control each output bit.
// (RULE17) Blocked edge pulses keep stored condition; compare against it afterwards.
// (RULE18) Edge bit skipped by a jump keeps its last state.
// (RULE19) Program start clears every stored edge condition to OFF.
`timescale 1ns/1ps
`include "ledl_defines.svh"

module ledl_core import ledl_pkg::*; (
    input  wire logic                        clk_in,
    input  wire logic                        reset_in,
    input  wire logic                        program_start_in,
    input  wire logic                        power_restore_in,
    input  wire logic                        step_valid_in,
    input  wire ledl_opcode_type             opcode_in,
    input  wire logic                        cond_in,
    input  wire logic                        reset_cond_in,
    input  wire logic [`LEDL_SLOT_AW-1:0]    slot_in,
    input  wire logic [`LEDL_BIT_AW-1:0]     bit_addr_in,
    input  wire logic [`LEDL_FLAG_W-1:0]     flags_in,
    output logic      [`LEDL_BIT_COUNT-1:0]  bit_image_out,
    output logic                             designated_bit_out,
    output logic                             interlock_active_out,
    output logic                             coil_force_off_out,
    output logic                             timer_reset_out,
    output logic                             counter_hold_out,
    output logic                             instr_enable_out,
    output logic                             line_cond_out,
    output logic                             step_done_out,
    output logic      [`LEDL_FLAG_W-1:0]     flags_out,
    output logic                             clear_without_open_out
);

    ledl_state_type                state;
    ledl_state_type                next_state;
    logic [`LEDL_BIT_COUNT-1:0]    retain_mask;
    logic                          edge_pulse;
    logic                          latch_next;
    logic                          prev_sel;
    logic                          bit_sel;
    logic                          is_falling;

    function automatic logic area_retentive(input logic [1:0] area);
        area_retentive = (area == `LEDL_AREA_HOLDING) || (area == `LEDL_AREA_AUX);
    endfunction : area_retentive

    // Mask of bits that live in retentive areas
    genvar gi;
    generate
        for (gi = 0; gi < `LEDL_BIT_COUNT; gi = gi + 1) begin : g_retain
            localparam logic [`LEDL_BIT_AW-1:0] ADDR = `LEDL_BIT_AW'(gi);
            assign retain_mask[gi] = area_retentive(ADDR[`LEDL_AREA_MSB:`LEDL_AREA_LSB]);
        end
    endgenerate

    assign prev_sel   = state.prev_mem[slot_in];
    assign bit_sel    = state.bit_mem[bit_addr_in];
    assign is_falling = (opcode_in == LEDL_OP_FALL);

    ledl_edge_unit u_edge (
        .prev_in    (prev_sel),
        .cond_in    (cond_in),
        .falling_in (is_falling),
        .pulse_out  (edge_pulse)
    );

    ledl_latch_unit u_latch (
        .current_in (bit_sel),
        .set_in     (cond_in),
        .clear_in   (reset_cond_in),
        .next_out   (latch_next)
    );

    always_comb begin
        next_state              = state;
        next_state.done         = 1'b0;
        next_state.coil_off     = 1'b0;
        next_state.timer_rst    = 1'b0;
        next_state.counter_hold = 1'b0;
        next_state.instr_en     = 1'b0;
        next_state.line_cond    = 1'b0;
        if (program_start_in) begin
            next_state.prev_mem = `LEDL_PREV_RESET;  // see (RULE19)
            next_state.blocked  = 1'b0;
            next_state.opened   = 1'b0;
        end else if (power_restore_in) begin
            // Restart after power loss: only retentive areas keep their bits
            next_state.bit_mem  = state.bit_mem & retain_mask;  // see (RULE10)
            next_state.prev_mem = `LEDL_PREV_RESET;  // see (RULE19)
            next_state.blocked  = 1'b0;
            next_state.opened   = 1'b0;
        end else if (step_valid_in) begin
            next_state.done      = 1'b1;
            next_state.instr_en  = ~state.blocked;  // see (RULE13)
            next_state.line_cond = ~state.blocked;  // see (RULE12)
            case (opcode_in)
                LEDL_OP_RISE, LEDL_OP_FALL: begin
                    // Flags untouched here; blocked section keeps bit and stored value
                    if (!state.blocked) begin  // see (RULE17) (RULE6)
                        next_state.bit_mem[bit_addr_in] = edge_pulse;  // see (RULE1)
                        next_state.prev_mem[slot_in]    = cond_in;     // see (RULE1)
                    end
                end
                LEDL_OP_LATCH: begin
                    if (!state.blocked) begin  // see (RULE11) (RULE13) (RULE6)
                        next_state.bit_mem[bit_addr_in] = latch_next;
                    end
                end
                LEDL_OP_IL_OPEN: begin
                    // Each further open may only add blocking up to the clear
                    if (!cond_in) begin
                        next_state.blocked = 1'b1;  // see (RULE14)
                    end
                    next_state.opened    = 1'b1;  // see (RULE14)
                    next_state.instr_en  = 1'b0;
                    next_state.line_cond = 1'b0;
                end
                LEDL_OP_IL_CLEAR: begin
                    if (!state.opened) begin
                        next_state.bad_clear = 1'b1;  // see (RULE15)
                    end
                    next_state.blocked   = 1'b0;
                    next_state.opened    = 1'b0;
                    next_state.instr_en  = 1'b1;
                    next_state.line_cond = 1'b1;
                end
                LEDL_OP_COIL: begin
                    next_state.coil_off = state.blocked;  // see (RULE13)
                end
                LEDL_OP_TIMER, LEDL_OP_FAST_TIMER: begin
                    next_state.timer_rst = state.blocked;  // see (RULE13)
                end
                LEDL_OP_COUNTER, LEDL_OP_REV_COUNTER: begin
                    next_state.counter_hold = state.blocked;  // see (RULE13)
                end
                LEDL_OP_OTHER: begin
                    if (!state.blocked) begin  // see (RULE13)
                        next_state.flags = flags_in;
                    end
                end
                LEDL_OP_JUMP_SKIPPED: begin
                    // Skipped instruction leaves every bit as it stands
                    next_state.instr_en  = 1'b0;  // see (RULE18)
                    next_state.line_cond = 1'b0;
                end
                default: begin
                    next_state.instr_en = ~state.blocked;
                end
            endcase
        end
        next_state.sel_bit = next_state.bit_mem[bit_addr_in];
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state              <= '0;
            state.bit_mem      <= `LEDL_BITS_RESET;
            state.prev_mem     <= `LEDL_PREV_RESET;  // see (RULE19)
            state.flags        <= `LEDL_FLAGS_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign bit_image_out          = state.bit_mem;
    assign designated_bit_out     = state.sel_bit;
    assign interlock_active_out   = state.blocked;
    assign coil_force_off_out     = state.coil_off;
    assign timer_reset_out        = state.timer_rst;
    assign counter_hold_out       = state.counter_hold;
    assign instr_enable_out       = state.instr_en;
    assign line_cond_out          = state.line_cond;
    assign step_done_out          = state.done;
    assign flags_out              = state.flags;
    assign clear_without_open_out = state.bad_clear;

endmodule : ledl_core

// >>> shared/ledl_defines.svh
`ifndef LEDL_DEFINES_SVH
`define LEDL_DEFINES_SVH

// Bit image, edge-instruction memory and flag sizes
`define LEDL_BIT_COUNT    64
`define LEDL_BIT_AW       6
`define LEDL_SLOT_COUNT   32
`define LEDL_SLOT_AW      5
`define LEDL_FLAG_W       4

// Area field inside a bit address
`define LEDL_AREA_MSB     5
`define LEDL_AREA_LSB     4
`define LEDL_AREA_IO      2'h0
`define LEDL_AREA_LINK    2'h1
`define LEDL_AREA_HOLDING 2'h2
`define LEDL_AREA_AUX     2'h3

// Reset values
`define LEDL_BITS_RESET   64'h0000_0000_0000_0000
`define LEDL_PREV_RESET   32'h0000_0000
`define LEDL_FLAGS_RESET  4'h0

`endif

// >>> shared/ledl_pkg.sv
`include "ledl_defines.svh"

package ledl_pkg;

    typedef enum logic [3:0] {
        LEDL_OP_NOP          = 4'h0,
        LEDL_OP_RISE         = 4'h1,
        LEDL_OP_LATCH        = 4'h2,
        LEDL_OP_FALL         = 4'h3,
        LEDL_OP_TIMER        = 4'h4,
        LEDL_OP_COIL         = 4'h5,
        LEDL_OP_IL_OPEN      = 4'h6,
        LEDL_OP_IL_CLEAR     = 4'h7,
        LEDL_OP_JUMP_SKIPPED = 4'ha,
        LEDL_OP_FAST_TIMER   = 4'hc,
        LEDL_OP_COUNTER      = 4'hd,
        LEDL_OP_OTHER        = 4'he,
        LEDL_OP_REV_COUNTER  = 4'hf
    } ledl_opcode_type;

    typedef struct packed {
        logic [`LEDL_BIT_COUNT-1:0]  bit_mem;
        logic [`LEDL_SLOT_COUNT-1:0] prev_mem;
        logic                        blocked;
        logic                        opened;
        logic [`LEDL_FLAG_W-1:0]     flags;
        logic                        sel_bit;
        logic                        coil_off;
        logic                        timer_rst;
        logic                        counter_hold;
        logic                        instr_en;
        logic                        line_cond;
        logic                        done;
        logic                        bad_clear;
    } ledl_state_type;

endpackage : ledl_pkg

// >>> logic/ledl_edge_unit.sv
`timescale 1ns/1ps

module ledl_edge_unit import ledl_pkg::*; (
    input  wire logic prev_in,
    input  wire logic cond_in,
    input  wire logic falling_in,
    output logic      pulse_out
);

    always_comb begin
        if (falling_in) begin
            pulse_out = prev_in & ~cond_in;  // see (RULE4) (RULE5)
        end else begin
            pulse_out = ~prev_in & cond_in;  // see (RULE2) (RULE3)
        end
    end

endmodule : ledl_edge_unit

// >>> logic/ledl_latch_unit.sv
`timescale 1ns/1ps

module ledl_latch_unit import ledl_pkg::*; (
    input  wire logic current_in,
    input  wire logic set_in,
    input  wire logic clear_in,
    output logic      next_out
);

    always_comb begin
        if (clear_in) begin
            next_out = 1'b0;        // see (RULE8) (RULE9)
        end else if (set_in) begin
            next_out = 1'b1;        // see (RULE7)
        end else begin
            next_out = current_in;  // see (RULE7) (RULE8)
        end
    end

endmodule : ledl_latch_unit

// >>> tb/ledl_core_asserts.sv
`timescale 1ns/1ps
`include "ledl_defines.svh"
module ledl_core_asserts import ledl_pkg::*; (
    input wire logic                    clk_in,
    input wire logic                    reset_in,
    input wire logic                    program_start_in,
    input wire logic                    power_restore_in,
    input wire logic                    step_valid_in,
    input wire ledl_opcode_type         opcode_in,
    input wire logic                    cond_in,
    input wire logic                    reset_cond_in,
    input wire logic [`LEDL_FLAG_W-1:0] flags_out,
    input wire logic                    designated_bit_out,
    input wire logic                    interlock_active_out,
    input wire logic                    coil_force_off_out,
    input wire logic                    timer_reset_out,
    input wire logic                    counter_hold_out,
    input wire logic                    line_cond_out,
    input wire logic                    step_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    logic acc;
    logic blk;
    assign acc = step_valid_in && !program_start_in && !power_restore_in;
    assign blk = interlock_active_out;
    property p_done; acc |=> step_done_out; endproperty
    a_done: assert property (p_done) else $error("step not completed");
    property p_refuse; step_valid_in && !acc |=> !step_done_out; endproperty
    a_refuse: assert property (p_refuse) else $error("refused step completed");
    property p_flags; !(acc && opcode_in == LEDL_OP_OTHER) |=> $stable(flags_out); endproperty
    a_flags: assert property (p_flags) else $error("flags changed");
    property p_open; acc && opcode_in == LEDL_OP_IL_OPEN && !cond_in |=> blk; endproperty
    a_open: assert property (p_open) else $error("interlock not active");
    property p_clear; acc && opcode_in == LEDL_OP_IL_CLEAR |=> !blk; endproperty
    a_clear: assert property (p_clear) else $error("interlock not cleared");
    property p_coil; acc && opcode_in == LEDL_OP_COIL && blk |=> coil_force_off_out; endproperty
    a_coil: assert property (p_coil) else $error("coil not forced off");
    property p_timer;
        acc && blk && opcode_in inside {LEDL_OP_TIMER, LEDL_OP_FAST_TIMER} |=> timer_reset_out;
    endproperty
    a_timer: assert property (p_timer) else $error("timer not reset");
    property p_hold;
        acc && blk && opcode_in inside {LEDL_OP_COUNTER, LEDL_OP_REV_COUNTER} |=> counter_hold_out;
    endproperty
    a_hold: assert property (p_hold) else $error("counter not held");
    property p_line;
        acc && !blk && opcode_in == LEDL_OP_COIL |=> line_cond_out && !coil_force_off_out;
    endproperty
    a_line: assert property (p_line) else $error("line not started on");
    property p_both;
        acc && !blk && opcode_in == LEDL_OP_LATCH && cond_in && reset_cond_in |=> !designated_bit_out;
    endproperty
    a_both: assert property (p_both) else $error("latch reset lost");
endmodule : ledl_core_asserts

bind ledl_core ledl_core_asserts u_chk (.*);

// >>> tb/ledl_seq_model.sv
`timescale 1ns/1ps
module ledl_seq_model import ledl_pkg::*; (
    input  wire logic       clk_in,
    output logic            start_out,
    output logic            restore_out,
    output logic            valid_out,
    output ledl_opcode_type opcode_out,
    output logic            cond_out,
    output logic            rcond_out,
    output logic [4:0]      slot_out,
    output logic [5:0]      addr_out,
    output logic [3:0]      flags_out
);
    initial begin
        {start_out, restore_out, valid_out, cond_out, rcond_out} = 5'h0;
        {slot_out, addr_out, flags_out} = 15'h0000;
        opcode_out = LEDL_OP_NOP;
    end
    // Presents one instruction step just after a rising edge
    task automatic issue(input logic v, ps, pr, input ledl_opcode_type op, input logic c, r,
                         input logic [4:0] s, input logic [5:0] a, input logic [3:0] f);
        @(posedge clk_in);
        {valid_out, start_out, restore_out, cond_out, rcond_out} <= {v, ps, pr, c, r};
        {opcode_out, slot_out, addr_out, flags_out} <= {op, s, a, f};
    endtask : issue
endmodule : ledl_seq_model

// >>> tb/ledl_core_tb.sv
`timescale 1ns/1ps
module ledl_core_tb import ledl_pkg::*;;
    logic clk_in, reset_in, program_start_in, power_restore_in, step_valid_in;
    logic cond_in, reset_cond_in;
    ledl_opcode_type opcode_in;
    logic [4:0] slot_in;
    logic [5:0] bit_addr_in;
    logic [3:0] flags_in, flags_out;
    logic [63:0] bit_image_out;
    logic designated_bit_out, interlock_active_out, coil_force_off_out, timer_reset_out;
    logic counter_hold_out, instr_enable_out, line_cond_out, step_done_out, clear_without_open_out;
    logic [31:0] rn;
    int err_total, n_tests, seed, k, opened, blk, flg, e_v, e_op, e_a, e_blk, ad, e_en;
    int bits[64];
    int prev[32];
    ledl_core dut (.*);
    ledl_seq_model seq (.clk_in(clk_in), .start_out(program_start_in),
        .restore_out(power_restore_in), .valid_out(step_valid_in), .opcode_out(opcode_in),
        .cond_out(cond_in), .rcond_out(reset_cond_in), .slot_out(slot_in),
        .addr_out(bit_addr_in), .flags_out(flags_in));
    initial begin
        clk_in = 0;
        forever #10 clk_in = ~clk_in;
    end
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    // Drive one step, check the previous one, then advance the reference model
    task automatic step(input logic v, ps, pr, input int op, c, r, s, a, f);
        seq.issue(v, ps, pr, ledl_opcode_type'(op), c[0], r[0], 5'(s), 6'(a), 4'(f));
        #1;
        chk("done", step_done_out, e_v);
        chk("flags", flags_out, flg);
        chk("interlock", interlock_active_out, blk);
        chk("badclear", clear_without_open_out, 0);
        if (e_v) begin
            e_en = e_op == 7 || (!e_blk && e_op != 6 && e_op != 10);
            chk("coil", coil_force_off_out, e_op == 5 && e_blk);
            chk("timer", timer_reset_out, (e_op == 4 || e_op == 12) && e_blk);
            chk("hold", counter_hold_out, (e_op == 13 || e_op == 15) && e_blk);
            chk("enable", instr_enable_out, e_en);
            chk("line", line_cond_out, e_en);
            if (e_op inside {1, 2, 3}) begin
                chk("dbit", designated_bit_out, bits[e_a]);
            end
        end
        for (int i = 0; i < 64; i++) begin
            chk("image", bit_image_out[i], bits[i]);
        end
        e_v = v && !ps && !pr;
        e_op = op;
        e_a = a;
        e_blk = blk;
        if (ps || pr) begin
            blk = 0;
            opened = 0;
            foreach (prev[i]) prev[i] = 0;
            if (!ps) begin
                for (int i = 0; i < 32; i++) bits[i] = 0;
            end
        end else if (v) begin
            if (op == 6) opened = 1;
            if (op == 6 && !c) blk = 1;
            if (op == 7) begin
                blk = 0;
                opened = 0;
            end
            if (!e_blk) begin
                case (op)
                    1: begin
                        bits[a] = !prev[s] && c;
                        prev[s] = c;
                    end
                    3: begin
                        bits[a] = prev[s] && !c;
                        prev[s] = c;
                    end
                    2: begin
                        if (r) bits[a] = 0;
                        else if (c) bits[a] = 1;
                    end
                    14: flg = f;
                    default: ;
                endcase
            end
        end
    endtask : step
    initial begin
        seed = 7747;
        reset_in = 1;
        repeat (4) @(posedge clk_in);
        reset_in <= 0;
        for (int n = 0; n < 800; n++) begin
            rn = $random(seed);
            k = $random(seed) & 15;
            if (k inside {8, 9, 11}) k = 0;
            if (k == 7 && !opened) k = 6;
            // One kind of instruction per bit, one stored slot per edge bit
            ad = (rn[20:15] & 60) | (k & 3);
            step(rn[0] | rn[1], rn[9:5] == 0, rn[14:10] == 0, k, rn[2], rn[3], ad >> 1, ad,
                 rn[24:21]);
        end
        step(0, 0, 0, 0, 0, 0, 0, 0, 0);
        tally_and_finish();
    end
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule : ledl_core_tb
